// ---- src/tuning_regs_defs.vh ----
/*
 * Register offsets, field positions, reset values and codes for the
 * down-converter tuning register group.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef TUNING_REGS_DEFS_VH
`define TUNING_REGS_DEFS_VH

// Register addresses on the serial control port (15-bit address space).
`define OFS_LOAD_MODE 15'h0164
`define OFS_FEATURE 15'h0165
`define OFS_FREQ_PICK 15'h0166
`define OFS_RATE_LOW 15'h0167
`define OFS_RATE_HIGH 15'h0168
`define OFS_GLOBAL 15'h0169
`define OFS_ZONE 15'h016b

// Reset values of the stored registers.
`define RST_LOAD_MODE 8'h00
`define RST_FEATURE 8'h00
`define RST_FREQ_PICK 8'h00
`define RST_RATE 8'h00
`define RST_GLOBAL 8'h00
`define RST_ZONE 8'h00

// Field positions in the load and mode register.
`define BIT_PHASE_MODE 0
`define BIT_NEG_IMAGE 3
`define LSB_OSC_LOAD 4

// Field positions in the feature control register.
`define BIT_COMMON_LOAD 0
`define BIT_REG_SELECT 1
`define BIT_AUTOLOAD_DIS 2
`define BIT_LOW_LATENCY 4

// Field positions in the global configuration register.
`define BIT_UNEQUAL 7
`define LSB_PATH_COUNT 4
`define BIT_QUAD_ENABLE 2

// Field positions in the sampling-zone register.
`define BIT_ZONE_LOAD 4

// Path count codes.
`define PATHS_DUAL 2'h0
`define PATHS_QUAD 2'h1
`define PATHS_SINGLE 2'h2

// Highest valid sampling-zone code (sixth zone).
`define ZONE_MAX 3'h5

`endif

// ---- src/rise_detect.v ----
/*
 * Rising-edge detector for a stored strobe bit, one pulse per 0-to-1 step.
 * Assumes the input is a register in the same clock domain.
 */
`timescale 1ns/10ps
module rise_detect (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_level,
   output wire o_rise
);
   // Previous value; reset to zero so a bit already one at reset gives an edge.
   reg prev_q;

   // Track the level each cycle.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= i_level;
      end
   end

   // Holding the level high gives no further pulse.
   assign o_rise = i_level & ~prev_q;
endmodule // rise_detect

// ---- src/rate_decode.v ----
/*
 * Decodes a four-bit decimation code into a log2 factor and bypass flag.
 * Assumes pure combinational use; no clock.
 */
`timescale 1ns/10ps
module rate_decode (
   input wire [3:0] i_code,
   output wire o_bypass,
   output wire [3:0] o_log2
);
   // Code zero bypasses; code n divides by 2 to the power n.
   assign o_bypass = (i_code == 4'h0);
   assign o_log2 = i_code;
endmodule // rate_decode

// ---- src/downconverter_tuning_regs.v ----
/*
 * Tuning register group of a four-path digital down-converter: frequency
 * load strobes, oscillator mode, frequency pick, bypass and decimation.
 * Assumes a serial control port front end that delivers one-cycle write
 * and read strobes with address and data in the device clock domain.
 */
//
// Operation
// - Per-oscillator load bit rising edge loads it.
// - Negative image applies only in complex mode.
// - Phase mode: zero continuous, one coherent.
// - Low-latency bit bypasses all processing.
// - Autoload disable blocks pin-switch frequency loads.
// - Source bit picks pins or select register.
// - Common load edge loads all four oscillators.
// - Two-bit pick per path, path three top.
// - Rate pairs: odd path high, even low.
// - Per-path rates only with unequal bit set.
// - Rate codes: bypass, 2, 4, up to 32768.
// - Unequal bit chooses common or individual factors.
// - Path count: dual, quad, single; 11 unused.
// - Common rate field in lowest four bits.
// - Zone load edge copies zone to working.
// - Zone codes 000 to 101; others unused.
// - Complex enable selects real or complex decimation.
`timescale 1ns/10ps
`include "tuning_regs_defs.vh"
module downconverter_tuning_regs (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [14:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [7:0] i_pin_pick,
   output reg [7:0] o_rdata,
   output reg o_rvalid,
   output reg [3:0] o_osc_load,
   output reg [7:0] o_active_pick,
   output reg o_phase_coherent,
   output reg o_neg_image,
   output reg o_low_latency,
   output reg o_complex_mode,
   output reg [1:0] o_path_count,
   output reg [15:0] o_path_log2,
   output reg [3:0] o_path_bypass,
   output reg [2:0] o_zone_work,
   output reg o_zone_valid
);
   // Stored registers, one byte each.
   reg [7:0] load_mode_q;
   reg [7:0] feature_q;
   reg [7:0] freq_pick_q;
   reg [7:0] rate_low_q;
   reg [7:0] rate_high_q;
   reg [7:0] global_q;
   reg [7:0] zone_q;
   // Last sampled pin pick, used to spot a pin-driven frequency switch.
   reg [7:0] pin_prev_q;

   // Edge pulses from the load strobes.
   wire [3:0] osc_rise;
   wire common_rise;
   wire zone_rise;
   // Decoded decimation per path.
   wire [3:0] path_code [0:3];
   wire [3:0] dec_bypass;
   wire [3:0] dec_log2 [0:3];
   wire [15:0] dec_log2_flat;
   // Frequency selection and automatic load from a pin switch.
   wire reg_source;
   wire [7:0] pick_now;
   wire pin_switch;
   wire auto_load;

   // Register writes; reserved must-write-zero bits are kept as written.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_mode_q <= `RST_LOAD_MODE;
         feature_q <= `RST_FEATURE;
         freq_pick_q <= `RST_FREQ_PICK;
         rate_low_q <= `RST_RATE;
         rate_high_q <= `RST_RATE;
         global_q <= `RST_GLOBAL;
         zone_q <= `RST_ZONE;
      end else if (i_wr_en) begin
         case (i_addr)
            `OFS_LOAD_MODE: begin
               load_mode_q <= i_wdata;
            end
            `OFS_FEATURE: begin
               feature_q <= i_wdata;
            end
            `OFS_FREQ_PICK: begin
               freq_pick_q <= i_wdata;
            end
            `OFS_RATE_LOW: begin
               rate_low_q <= i_wdata;
            end
            `OFS_RATE_HIGH: begin
               rate_high_q <= i_wdata;
            end
            `OFS_GLOBAL: begin
               global_q <= i_wdata;
            end
            `OFS_ZONE: begin
               zone_q <= i_wdata;
            end
            default: begin
               // Other addresses belong to other register groups.
               zone_q <= zone_q;
            end
         endcase
      end
   end

   // Registered read port; unmapped addresses read as zero.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd_en;
         if (i_rd_en) begin
            case (i_addr)
               `OFS_LOAD_MODE: o_rdata <= load_mode_q;
               `OFS_FEATURE: o_rdata <= feature_q;
               `OFS_FREQ_PICK: o_rdata <= freq_pick_q;
               `OFS_RATE_LOW: o_rdata <= rate_low_q;
               `OFS_RATE_HIGH: o_rdata <= rate_high_q;
               `OFS_GLOBAL: o_rdata <= global_q;
               `OFS_ZONE: o_rdata <= zone_q;
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // One edge detector per oscillator load bit.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_osc
         rise_detect u_osc_rise (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_level(load_mode_q[`LSB_OSC_LOAD + gi]),
            .o_rise(osc_rise[gi])
         );
      end
   endgenerate

   // Common load strobe edge.
   rise_detect u_common_rise (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_level(feature_q[`BIT_COMMON_LOAD]),
      .o_rise(common_rise)
   );

   // Zone load strobe edge.
   rise_detect u_zone_rise (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_level(zone_q[`BIT_ZONE_LOAD]),
      .o_rise(zone_rise)
   );

   // Frequency source: pins while the source bit is clear.
   assign reg_source = feature_q[`BIT_REG_SELECT];
   assign pick_now = reg_source ? freq_pick_q : i_pin_pick;

   // A pin change in pin mode loads unless auto-load is disabled.
   assign pin_switch = ~reg_source & (i_pin_pick != pin_prev_q);
   assign auto_load = pin_switch & ~feature_q[`BIT_AUTOLOAD_DIS];

   // Per-path codes: common field unless unequal decimation is set.
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_path
         // Even paths take the low nibble, odd paths the high nibble.
         assign path_code[gi] = global_q[`BIT_UNEQUAL] ?
            ((gi < 2) ?
             ((gi % 2 == 1) ? rate_low_q[7:4] : rate_low_q[3:0]) :
             ((gi % 2 == 1) ? rate_high_q[7:4] : rate_high_q[3:0])) :
            global_q[3:0];
         rate_decode u_dec (
            .i_code(path_code[gi]),
            .o_bypass(dec_bypass[gi]),
            .o_log2(dec_log2[gi])
         );
         assign dec_log2_flat[4 * gi + 3:4 * gi] = dec_log2[gi];
      end
   endgenerate

   // Pin history and all registered outputs but the read port.
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_prev_q <= 8'h00;
         o_osc_load <= 4'h0;
         o_active_pick <= 8'h00;
         o_phase_coherent <= 1'b0;
         o_neg_image <= 1'b0;
         o_low_latency <= 1'b0;
         o_complex_mode <= 1'b0;
         o_path_count <= `PATHS_DUAL;
         o_path_log2 <= 16'h0000;
         o_path_bypass <= 4'h0;
         o_zone_work <= 3'h0;
         o_zone_valid <= 1'b1;
      end else begin
         pin_prev_q <= i_pin_pick;
         // Common edge or automatic pin load reaches all four oscillators.
         o_osc_load <= osc_rise | {4{common_rise | auto_load}};
         o_active_pick <= pick_now;
         o_phase_coherent <= load_mode_q[`BIT_PHASE_MODE];
         o_complex_mode <= global_q[`BIT_QUAD_ENABLE];
         // Negative image is meaningless for real decimation, so gate it.
         o_neg_image <= load_mode_q[`BIT_NEG_IMAGE] &
            global_q[`BIT_QUAD_ENABLE];
         o_low_latency <= feature_q[`BIT_LOW_LATENCY];
         o_path_count <= global_q[`LSB_PATH_COUNT + 1:`LSB_PATH_COUNT];
         // Low latency forces every path into bypass.
         o_path_log2 <= feature_q[`BIT_LOW_LATENCY] ? 16'h0000 :
            dec_log2_flat;
         o_path_bypass <= dec_bypass | {4{feature_q[`BIT_LOW_LATENCY]}};
         if (zone_rise) begin
            o_zone_work <= zone_q[2:0];
            o_zone_valid <= (zone_q[2:0] <= `ZONE_MAX);
         end
      end
   end
endmodule // downconverter_tuning_regs

// ---- testbench/tuning_regs_monitor.sv ----
/* Checker for the tuning register group: port timing relations.
   Assumes it is bound to every instance of downconverter_tuning_regs. */
`timescale 1ns/10ps
module tuning_regs_monitor (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [14:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire o_rvalid,
   input wire [3:0] o_osc_load,
   input wire o_phase_coherent,
   input wire o_neg_image,
   input wire o_low_latency,
   input wire o_complex_mode,
   input wire [1:0] o_path_count,
   input wire [15:0] o_path_log2,
   input wire [3:0] o_path_bypass,
   input wire [2:0] o_zone_work,
   input wire o_zone_valid
);
   // One clock domain, so one default clock and reset serve every check.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // A strobe bit written low, then high; the pair makes one load edge.
   sequence s_clr(a, b); i_wr_en && i_addr == a && !i_wdata[b]; endsequence
   sequence s_set(a, b); i_wr_en && i_addr == a && i_wdata[b]; endsequence
   // Writes to the mode and global registers.
   wire wr_mode = i_wr_en && i_addr == 15'h0164;
   wire wr_glob = i_wr_en && i_addr == 15'h0169;
   a_osc_zero_load:
      assert property (s_clr(15'h0164, 4) ##1 s_set(15'h0164, 4)
         |-> ##[1:3] o_osc_load[0]) else $error("lone load lost");
   a_common_load_all:
      assert property (s_clr(15'h0165, 0) ##1 s_set(15'h0165, 0)
         |-> ##[1:3] o_osc_load == 4'hf) else $error("common load lost");
   a_read_answer: assert property (i_rd_en |=> o_rvalid)
      else $error("read got no answer");
   a_answer_cause: assert property (o_rvalid |-> $past(i_rd_en))
      else $error("answer without read");
   a_unmapped_zero: assert property (i_rd_en && (i_addr < 15'h0164 ||
      i_addr > 15'h016b || i_addr == 15'h016a) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_phase_mode_bit:
      assert property (wr_mode ##1 !wr_mode
         |=> o_phase_coherent == $past(i_wdata[0], 2))
      else $error("phase mode wrong");
   a_path_count_field:
      assert property (wr_glob ##1 !wr_glob
         |=> o_path_count == $past(i_wdata[5:4], 2))
      else $error("path count wrong");
   a_low_latency_bypass:
      assert property (o_low_latency |-> o_path_bypass == 4'hf
         && o_path_log2 == 16'h0000) else $error("bypass not total");
   a_neg_image_gate:
      assert property (o_neg_image |-> o_complex_mode)
      else $error("image outside complex mode");
   a_zone_valid_flag:
      assert property (o_zone_valid == (o_zone_work <= 3'h5))
      else $error("zone flag wrong");
endmodule // tuning_regs_monitor
bind downconverter_tuning_regs tuning_regs_monitor mon (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .o_osc_load(o_osc_load), .o_phase_coherent(o_phase_coherent),
   .o_neg_image(o_neg_image), .o_low_latency(o_low_latency),
   .o_complex_mode(o_complex_mode), .o_path_count(o_path_count),
   .o_path_log2(o_path_log2), .o_path_bypass(o_path_bypass),
   .o_zone_work(o_zone_work), .o_zone_valid(o_zone_valid));

// ---- testbench/test_downconverter_tuning_regs.sv ----
/* Self-checking bench for the tuning register group.
   Assumes the checker binds itself to the design from its own file. */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_downconverter_tuning_regs;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
   logic [14:0] i_addr = 15'h0000;
   logic [7:0] i_wdata = 8'h00, i_pin_pick = 8'h00, o_rdata, o_active_pick;
   logic o_rvalid, o_phase_coherent, o_neg_image, o_low_latency;
   logic o_complex_mode, o_zone_valid;
   logic [3:0] o_osc_load, o_path_bypass, seen;
   logic [1:0] o_path_count;
   logic [15:0] o_path_log2;
   logic [2:0] o_zone_work;
   int error_cnt = 0, num_checks = 0;
   logic [7:0] sh [0:7] = '{default: 8'h00}; // Expected, by offset - 0x164.
   always #12.5 i_clock = ~i_clock;
   downconverter_tuning_regs dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_pin_pick(i_pin_pick), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .o_osc_load(o_osc_load),
      .o_active_pick(o_active_pick), .o_phase_coherent(o_phase_coherent),
      .o_neg_image(o_neg_image), .o_low_latency(o_low_latency),
      .o_complex_mode(o_complex_mode), .o_path_count(o_path_count),
      .o_path_log2(o_path_log2), .o_path_bypass(o_path_bypass),
      .o_zone_work(o_zone_work), .o_zone_valid(o_zone_valid));
   // Strobe stays up so that two calls give back-to-back writes.
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      if (a != 15'h016a) sh[a[3:0] - 4'h4] = d;
   endtask
   // Idle cycles; outputs are compared one step after the last edge.
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge i_clock);
         i_wr_en <= 1'b0;
      end
      #1;
   endtask
   // The answer stands one cycle, so it is looked at right after the edge.
   task automatic rd(input logic [14:0] a);
      @(posedge i_clock);
      i_wr_en <= 1'b0;
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd_en <= 1'b0;
      #1;
      `CHK(o_rvalid, 1'b1)
      `CHK(o_rdata, sh[a[3:0] - 4'h4])
   endtask
   // Gathers the load pulses of a six-cycle window.
   task automatic loads(input logic [3:0] e);
      seen = 4'h0;
      repeat (6) begin
         idle(1);
         seen = seen | o_osc_load;
      end
      `CHK(seen, e)
   endtask
   // Expected {bypass, code} of path n; low latency overrides all.
   function automatic logic [4:0] path_exp(input int n);
      logic [3:0] c;
      c = sh[5][7] ? 4'((n[1] ? sh[4] : sh[3]) >> (4 * n[0])) : sh[5][3:0];
      return sh[1][4] ? 5'h10 : {c == 4'h0, c};
   endfunction
   // Compares every level output but the zone pair with the expected register contents.
   task automatic fields();
      idle(4);
      `CHK(o_phase_coherent, sh[0][0])
      `CHK(o_neg_image, sh[0][3] & sh[5][2])
      `CHK(o_low_latency, sh[1][4])
      `CHK(o_complex_mode, sh[5][2])
      `CHK(o_path_count, sh[5][5:4])
      for (int n = 0; n < 4; n++)
         `CHK({o_path_bypass[n], o_path_log2[4*n +: 4]}, path_exp(n))
      `CHK(o_active_pick, sh[1][1] ? sh[2] : i_pin_pick)
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      void'($urandom(89605));
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      // Reset values; a write to the hole must be ignored.
      wr(15'h016a, 8'h5a);
      for (int a = 'h164; a < 'h16c; a++) rd(15'(a));
      fields();
      $display("test reset done");
      // Random contents, read back as written and decoded per path.
      for (int k = 0; k < 40; k++) begin
         for (int a = 'h164; a < 'h16a; a++) wr(15'(a), 8'($urandom));
         i_pin_pick <= 8'($urandom);
         for (int a = 'h164; a < 'h16a; a++) rd(15'(a));
         fields();
      end
      $display("test random done");
      // Register pick keeps pins out; each strobe, a held one, the common.
      wr(15'h0165, 8'h02);
      for (int b = 4; b < 8; b++) begin
         wr(15'h0164, 8'h00);
         wr(15'h0164, 8'h01 << b);
         loads(4'h1 << (b - 4));
      end
      wr(15'h0164, 8'h80);
      loads(4'h0);
      // Clear then set back to back, so the checker sees the common edge.
      wr(15'h0165, 8'h02);
      wr(15'h0165, 8'h03);
      loads(4'hf);
      // Pin switching with automatic load on, then off.
      wr(15'h0165, 8'h00);
      idle(4);
      @(posedge i_clock);
      i_pin_pick <= ~i_pin_pick;
      loads(4'hf);
      wr(15'h0165, 8'h04);
      idle(4);
      @(posedge i_clock);
      i_pin_pick <= ~i_pin_pick;
      loads(4'h0);
      wr(15'h0166, 8'($urandom));
      wr(15'h0165, 8'h02);
      fields();
      $display("test loads done");
      // Every zone code, taken on the zone strobe edge.
      for (int z = 0; z < 8; z++) begin
         wr(15'h016b, 8'(z));
         wr(15'h016b, 8'(z) | 8'h10);
         idle(4);
         `CHK(o_zone_work, 3'(z))
         `CHK(o_zone_valid, z < 6)
      end
      $display("test zones done");
      stop_test();
   end
   // A hang is cut short and counted as a mismatch.
   initial begin
      repeat (40000) @(posedge i_clock);
      error_cnt++;
      stop_test();
   end
endmodule // test_downconverter_tuning_regs
